//--- rtl/iocrb_cell.sv
`timescale 1ns/10ps
module iocrb_cell (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic cfg_p,
	input wire logic pin_i,
	input wire logic dout_i,
	input wire logic oe_i,
	input wire logic ce_in,
	input wire logic ce_out,
	input wire logic clk_in_p,
	input wire logic clk_out_p,
	input wire logic aclr_i,
	input wire logic sclr_i,
	input wire logic [2:0] aclr_ign,
	input wire logic [2:0] sclr_ign,
	input wire logic pu_high,
	input wire logic in_reg_en,
	input wire logic out_reg_en,
	input wire logic oe_reg_en,
	input wire iocrb_pkg::iocrb_dly_t dly_a,
	input wire iocrb_pkg::iocrb_dly_t dly_b,
	input wire iocrb_pkg::iocrb_dly_t dly_o,
	output logic datain_a,
	output logic datain_b,
	output logic pad_out,
	output logic pad_oe,
	output logic in_v,
	output logic out_v,
	output logic oe_v
);
	logic in_q;
	logic out_q;
	logic oe_q;
	logic pin_d;
	logic [2:0] on_a;
	logic [2:0] on_s;

	function automatic logic reg_next(input logic q, input logic d, input logic ed, input logic ce,
		input logic s_on, input logic a_on, input logic pu, input logic cfg);
		reg_next = q;
		if (cfg || a_on)
			reg_next = pu;
		else if (ed && s_on)
			reg_next = pu;
		else if (ed && ce)
			reg_next = d;
	endfunction : reg_next

	assign on_a = {3{aclr_i}} & ~aclr_ign;
	assign on_s = {3{sclr_i}} & ~sclr_ign;

	iocrb_dly u_dly_a (.ref_clk(ref_clk), .rst_b(rst_b), .sel(dly_a), .d(pin_i), .q(pin_d));
	iocrb_dly u_dly_b (.ref_clk(ref_clk), .rst_b(rst_b), .sel(dly_b), .d(pin_i), .q(datain_b));
	iocrb_dly u_dly_o (.ref_clk(ref_clk), .rst_b(rst_b), .sel(dly_o), .d(out_reg_en ? out_v : dout_i),
		.q(pad_out));

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			in_q <= 1'b0;
		end else begin
			in_q <= reg_next(in_q, pin_d, clk_in_p, ce_in, on_s[0], on_a[0], pu_high, cfg_p);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_q <= 1'b0;
		end else begin
			out_q <= reg_next(out_q, dout_i, clk_out_p, ce_out, on_s[1], on_a[1], pu_high, cfg_p);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= reg_next(oe_q, oe_i, clk_out_p, ce_out, on_s[2], on_a[2], pu_high, cfg_p);
		end
	end

	// One sense bit per cell makes the control a clear or a preset, never both.
	assign in_v = on_a[0] ? pu_high : in_q;
	assign out_v = on_a[1] ? pu_high : out_q;
	assign oe_v = on_a[2] ? pu_high : oe_q;
	assign datain_a = in_reg_en ? in_v : pin_d;
	assign pad_oe = oe_reg_en ? oe_v : oe_i;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	aclr_clear_a: assert property (on_a[1] && !pu_high |-> !out_v)
		else $error("clear did not force zero");
	aclr_preset_a: assert property (on_a[2] && pu_high |-> oe_v)
		else $error("preset did not force one");
	ce_hold_a: assert property (clk_out_p && !ce_out && !on_a[1] && !on_s[1] && !cfg_p |=> out_q == $past(out_q))
		else $error("output register moved without enable");
	sync_clr_a: assert property (clk_out_p && on_s[1] && !on_a[1] && !cfg_p |=> out_q == $past(pu_high))
		else $error("sync reset missed");
	pair_clk_a: assert property (clk_out_p && ce_out && on_s[2:1] == 2'h0 && on_a[2:1] == 2'h0 && !cfg_p
		|=> out_q == $past(dout_i) && oe_q == $past(oe_i))
		else $error("output pair not loaded together");
	in_cap_a: assert property (clk_in_p && ce_in && !on_s[0] && !on_a[0] && !cfg_p |=> in_q == $past(pin_d))
		else $error("input register capture wrong");
	pu_load_a: assert property (cfg_p |=> {in_q, out_q, oe_q} == {3{$past(pu_high)}})
		else $error("power-up value not loaded");
	path_sel_a: assert property (in_reg_en |-> datain_a == in_v)
		else $error("registered path not on path a");

	out_load_c: cover property (clk_out_p && ce_out ##1 pad_oe);
	preset_c: cover property (on_a[1] && pu_high);
	in_reg_c: cover property (in_reg_en && clk_in_p && ce_in);
endmodule : iocrb_cell

//--- rtl/iocrb_cfg.svh
`ifndef IOCRB_CFG_SVH
`define IOCRB_CFG_SVH
`define IOCRB_NLANE 5
`define IOCRB_NGCLK 6
`define IOCRB_ROW_CELLS 5
`define IOCRB_COL_CELLS 4
`define IOCRB_DLY_STAGES 7
`define IOCRB_GCLK_BASE 4'h5
`define IOCRB_BLK_OFS 8'h00
`define IOCRB_STAT_OFS 8'h04
`define IOCRB_CELL_OFS 8'h10
`define IOCRB_BLK_RST 32'h0000000E
`define IOCRB_CTRL_RST 32'h00000000
`define IOCRB_SEL_RST 32'h000FFFFF
`define IOCRB_BLK_MASK 32'h0000000F
`define IOCRB_CTRL_MASK 32'h0007FFFF
`define IOCRB_SEL_MASK 32'h000FFFFF
`define IOCRB_B_DONE 0
`define IOCRB_B_ALANE 3:1
`define IOCRB_C_AIGN 2:0
`define IOCRB_C_SIGN 5:3
`define IOCRB_C_PUHI 6
`define IOCRB_C_INREG 7
`define IOCRB_C_OUTREG 8
`define IOCRB_C_OEREG 9
`define IOCRB_C_DLYA 12:10
`define IOCRB_C_DLYB 15:13
`define IOCRB_C_DLYO 18:16
`define IOCRB_S_OE 2:0
`define IOCRB_S_CEIN 5:3
`define IOCRB_S_CEOUT 8:6
`define IOCRB_S_SCLR 11:9
`define IOCRB_S_CKIN 15:12
`define IOCRB_S_CKOUT 19:16
`endif

//--- rtl/iocrb_dly.sv
`timescale 1ns/10ps
`include "iocrb_cfg.svh"
module iocrb_dly (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire iocrb_pkg::iocrb_dly_t sel,
	input wire logic d,
	output logic q
);
	logic [`IOCRB_DLY_STAGES-1:0] sr_q;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sr_q <= '0;
		end else begin
			sr_q <= {sr_q[`IOCRB_DLY_STAGES-2:0], d};
		end
	end

	// Setting zero bypasses the chain, n taps n cycles late.
	always_comb begin
		q = d;
		if (sel != 3'h0) begin
			q = sr_q[sel - 3'h1];
		end
	end
endmodule : iocrb_dly

//--- rtl/iocrb_pkg.sv
package iocrb_pkg;
	typedef logic [2:0] iocrb_lane_t;
	typedef logic [3:0] iocrb_src_t;
	typedef logic [2:0] iocrb_dly_t;
	typedef enum logic [2:0] {
		IOCRB_PH_IDLE = 3'b001,
		IOCRB_PH_WR = 3'b010,
		IOCRB_PH_RD = 3'b100
	} iocrb_phase_t;
endpackage : iocrb_pkg

//--- rtl/iocrb_top.sv
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "iocrb_cfg.svh"
// Summary of operation
// - Three registers per cell: input, output, enable.
// - Input register has its own clock, enable.
// - Output and enable registers share clock, enable.
// - Shared clears, each register may ignore either.
// - Cell chooses preset or clear, not both.
// - Registers load power-up value after configuration.
// - Power-up low makes control a clear.
// - Power-up high makes control a preset.
// - All registers of a cell share one control.
// - Synchronous reset acts on the clock edge.
// - One asynchronous clear source for the whole block.
// - Two input paths, each with own delay.
// - Input register takes one path, other combinational.
// - Row block five cells, column block four.
// - Row block takes seven five-bit lane groups.
// - Column block takes seven four-bit lane groups.
// - Two pin-to-array outputs per cell.
// - Six dedicated low-skew clocks feed the block.
// - Each cell selects its own control sources, except the asynchronous clear.
module iocrb_top #(
	parameter bit COLUMN_MODE = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [4:0] io_dataout,
	input wire logic [4:0] io_coe,
	input wire logic [4:0] io_cce_in,
	input wire logic [4:0] io_cce_out,
	input wire logic [4:0] io_cclk,
	input wire logic [4:0] io_caclr,
	input wire logic [4:0] io_csclr,
	input wire logic [5:0] io_clk,
	input wire logic [4:0] pad_in,
	output logic [4:0] pad_out,
	output logic [4:0] pad_oe,
	output logic [4:0] io_datain_a,
	output logic [4:0] io_datain_b
);
	localparam int NCELL = COLUMN_MODE ? `IOCRB_COL_CELLS : `IOCRB_ROW_CELLS;
	localparam int NL = `IOCRB_NLANE;

	logic addr_ok;
	logic wr_en;
	logic [3:0] wr_code_q;
	iocrb_pkg::iocrb_phase_t phase_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_word;
	logic [31:0] blk_q;
	logic [31:0] ctrl_q [0:4];
	logic [31:0] sel_q [0:4];
	logic done_q;
	logic cfg_p_q;
	logic [4:0] pin_s1_q;
	logic [4:0] pin_s2_q;
	logic aclr_blk;
	logic [4:0] in_v;
	logic [4:0] out_v;
	logic [4:0] oe_v;

	// Lanes beyond the populated cells fall back to the default level.
	function automatic logic lane_pick(input logic [NL-1:0] v, input iocrb_pkg::iocrb_lane_t c,
		input logic dflt);
		lane_pick = dflt;
		if (c < 3'(NCELL))
			lane_pick = v[c];
	endfunction : lane_pick

	// Codes below the cell count pick an array clock lane, codes five to ten a dedicated clock.
	function automatic logic clk_pick(input logic [NL-1:0] ac, input logic [`IOCRB_NGCLK-1:0] gc,
		input iocrb_pkg::iocrb_src_t s);
		logic [3:0] g;
		g = s - `IOCRB_GCLK_BASE;
		clk_pick = 1'b0;
		if (s < 4'(NCELL))
			clk_pick = ac[s[2:0]];
		else if (s >= `IOCRB_GCLK_BASE && g < 4'(`IOCRB_NGCLK))
			clk_pick = gc[g[2:0]];
	endfunction : clk_pick

	// Code 0 block control, 1 status, 2+2i cell control, 3+2i cell select, F unmapped.
	function automatic logic [3:0] reg_dec(input logic [31:0] a);
		reg_dec = 4'hF;
		if (a[31:8] == 24'h000000 && a[1:0] == 2'h0) begin
			if (a[7:0] == `IOCRB_BLK_OFS)
				reg_dec = 4'h0;
			else if (a[7:0] == `IOCRB_STAT_OFS)
				reg_dec = 4'h1;
			else if (a[7:0] >= `IOCRB_CELL_OFS && a[7:0] < `IOCRB_CELL_OFS + 8'(8 * NCELL))
				reg_dec = 4'(a[7:2] - 6'h02);
		end
	endfunction : reg_dec

	assign addr_ok = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_q <= iocrb_pkg::IOCRB_PH_IDLE;
		end else if (addr_ok) begin
			phase_q <= hwrite ? iocrb_pkg::IOCRB_PH_WR : iocrb_pkg::IOCRB_PH_RD;
		end else if (hready) begin
			phase_q <= iocrb_pkg::IOCRB_PH_IDLE;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_code_q <= 4'hF;
		end else if (addr_ok && hwrite) begin
			wr_code_q <= (hsize == 3'h2) ? reg_dec(haddr) : 4'hF;
		end
	end

	always_comb begin
		wr_en = 1'b0;
		case (phase_q)
			iocrb_pkg::IOCRB_PH_WR: wr_en = hready;
			iocrb_pkg::IOCRB_PH_IDLE: wr_en = 1'b0;
			iocrb_pkg::IOCRB_PH_RD: wr_en = 1'b0;
			default: wr_en = 1'b0;
		endcase
	end

	always_comb begin
		logic [3:0] c;
		c = reg_dec(haddr);
		rd_word = 32'h00000000;
		if (hsize != 3'h2)
			rd_word = 32'h00000000;
		else if (c == 4'h0)
			rd_word = blk_q;
		else if (c == 4'h1)
			rd_word = {12'h000, pin_s2_q, oe_v, out_v, in_v};
		else if (c != 4'hF && !c[0])
			rd_word = ctrl_q[3'(c[3:1] - 3'h1)];
		else if (c != 4'hF)
			rd_word = sel_q[3'(c[3:1] - 3'h1)];
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hrdata_q <= 32'h00000000;
		end else if (addr_ok && !hwrite) begin
			hrdata_q <= rd_word;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			blk_q <= `IOCRB_BLK_RST;
		end else if (wr_en && wr_code_q == 4'h0) begin
			blk_q <= hwdata & `IOCRB_BLK_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 5; i++) begin
				ctrl_q[i] <= `IOCRB_CTRL_RST;
				sel_q[i] <= `IOCRB_SEL_RST;
			end
		end else if (wr_en) begin
			for (int i = 0; i < 5; i++) begin
				if (wr_code_q == 4'(2 + 2 * i))
					ctrl_q[i] <= hwdata & `IOCRB_CTRL_MASK;
				if (wr_code_q == 4'(3 + 2 * i))
					sel_q[i] <= hwdata & `IOCRB_SEL_MASK;
			end
		end
	end

	// Setting the done bit marks the end of configuration and loads power-up values once.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			done_q <= 1'b0;
			cfg_p_q <= 1'b0;
		end else begin
			done_q <= blk_q[`IOCRB_B_DONE];
			cfg_p_q <= blk_q[`IOCRB_B_DONE] && !done_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_q <= 5'h00;
			pin_s2_q <= 5'h00;
		end else begin
			pin_s1_q <= pad_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	assign aclr_blk = lane_pick(io_caclr, blk_q[`IOCRB_B_ALANE], 1'b0);

	for (genvar g = 0; g < 5; g++) begin : g_cell
		if (g < NCELL) begin : g_on
			iocrb_cell u_cell (
				.ref_clk(ref_clk),
				.rst_b(rst_b),
				.cfg_p(cfg_p_q),
				.pin_i(pin_s2_q[g]),
				.dout_i(io_dataout[g]),
				.oe_i(lane_pick(io_coe, sel_q[g][`IOCRB_S_OE], 1'b0)),
				.ce_in(lane_pick(io_cce_in, sel_q[g][`IOCRB_S_CEIN], 1'b1)),
				.ce_out(lane_pick(io_cce_out, sel_q[g][`IOCRB_S_CEOUT], 1'b1)),
				.clk_in_p(clk_pick(io_cclk, io_clk, sel_q[g][`IOCRB_S_CKIN])),
				.clk_out_p(clk_pick(io_cclk, io_clk, sel_q[g][`IOCRB_S_CKOUT])),
				.aclr_i(aclr_blk),
				.sclr_i(lane_pick(io_csclr, sel_q[g][`IOCRB_S_SCLR], 1'b0)),
				.aclr_ign(ctrl_q[g][`IOCRB_C_AIGN]),
				.sclr_ign(ctrl_q[g][`IOCRB_C_SIGN]),
				.pu_high(ctrl_q[g][`IOCRB_C_PUHI]),
				.in_reg_en(ctrl_q[g][`IOCRB_C_INREG]),
				.out_reg_en(ctrl_q[g][`IOCRB_C_OUTREG]),
				.oe_reg_en(ctrl_q[g][`IOCRB_C_OEREG]),
				.dly_a(ctrl_q[g][`IOCRB_C_DLYA]),
				.dly_b(ctrl_q[g][`IOCRB_C_DLYB]),
				.dly_o(ctrl_q[g][`IOCRB_C_DLYO]),
				.datain_a(io_datain_a[g]),
				.datain_b(io_datain_b[g]),
				.pad_out(pad_out[g]),
				.pad_oe(pad_oe[g]),
				.in_v(in_v[g]),
				.out_v(out_v[g]),
				.oe_v(oe_v[g])
			);
		end else begin : g_off
			assign io_datain_a[g] = 1'b0;
			assign io_datain_b[g] = 1'b0;
			assign pad_out[g] = 1'b0;
			assign pad_oe[g] = 1'b0;
			assign in_v[g] = 1'b0;
			assign out_v[g] = 1'b0;
			assign oe_v[g] = 1'b0;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	wr_store_a: assert property (wr_en && wr_code_q == 4'h2 |=> ctrl_q[0] == ($past(hwdata) & `IOCRB_CTRL_MASK))
		else $error("cell control write not stored");
	rd_blk_a: assert property (addr_ok && !hwrite && hsize == 3'h2 && reg_dec(haddr) == 4'h0 |=> hrdata == $past(blk_q))
		else $error("block control read wrong");
	cfg_once_a: assert property (cfg_p_q |=> !cfg_p_q [*3])
		else $error("configuration pulse repeated");
	col_tie_a: assert property (COLUMN_MODE |-> pad_oe[4] == 1'b0 && io_datain_a[4] == 1'b0)
		else $error("absent column cell active");
	shared_clr_a: assert property (aclr_blk && ctrl_q[0][1] == 1'b0 && ctrl_q[1][1] == 1'b0
		|-> out_v[0] == ctrl_q[0][`IOCRB_C_PUHI] && out_v[1] == ctrl_q[1][`IOCRB_C_PUHI])
		else $error("shared clear not seen by all cells");

	// The bus answers in zero wait states and never reports an error.
	ready_high_a: assert property (hreadyout == 1'b1)
		else $error("slave inserted a wait state");

	resp_okay_a: assert property (hresp == 1'b0)
		else $error("slave answered with an error");

	phase_wr_a: assert property (addr_ok && hwrite |=> phase_q == iocrb_pkg::IOCRB_PH_WR)
		else $error("write address phase not taken");

	phase_rd_a: assert property (addr_ok && !hwrite |=> phase_q == iocrb_pkg::IOCRB_PH_RD)
		else $error("read address phase not taken");

	rd_unmap_a: assert property (addr_ok && !hwrite && reg_dec(haddr) == 4'hF |=> hrdata == 32'h00000000)
		else $error("unmapped read not zero");

	rd_size_a: assert property (addr_ok && !hwrite && hsize != 3'h2 |=> hrdata == 32'h00000000)
		else $error("narrow read not zero");

	rd_pins_a: assert property (addr_ok && !hwrite && hsize == 3'h2 && reg_dec(haddr) == 4'h1
		|=> hrdata[19:15] == $past(pin_s2_q))
		else $error("status read lost the pin levels");

	rd_cells_a: assert property (addr_ok && !hwrite && hsize == 3'h2 && reg_dec(haddr) == 4'h1
		|=> hrdata[4:0] == $past(in_v) && hrdata[9:5] == $past(out_v) && hrdata[14:10] == $past(oe_v))
		else $error("status read lost the register values");

	wr_blk_a: assert property (wr_en && wr_code_q == 4'h0 |=> blk_q == ($past(hwdata) & `IOCRB_BLK_MASK))
		else $error("block control write not stored");

	wr_sel_a: assert property (wr_en && wr_code_q == 4'h3 |=> sel_q[0] == ($past(hwdata) & `IOCRB_SEL_MASK))
		else $error("cell select write not stored");

	wr_drop_a: assert property (wr_en && wr_code_q == 4'hF
		|=> blk_q == $past(blk_q) && ctrl_q[0] == $past(ctrl_q[0]))
		else $error("dropped write changed a register");

	blk_bits_a: assert property (blk_q[31:4] == 28'h0000000)
		else $error("block control holds unused bits");

	ctrl_bits_a: assert property (ctrl_q[0][31:19] == 13'h0000)
		else $error("cell control holds unused bits");

	sel_bits_a: assert property (sel_q[0][31:20] == 12'h000)
		else $error("cell select holds unused bits");

	cfg_edge_a: assert property (cfg_p_q |-> done_q && !$past(done_q))
		else $error("power-up load without done edge");

	cfg_rise_a: assert property ($rose(done_q) |-> cfg_p_q)
		else $error("done edge gave no power-up load");

	pu_cell_a: assert property (cfg_p_q |=> in_v[0] == $past(ctrl_q[0][`IOCRB_C_PUHI]))
		else $error("input register missed power-up value");

	sync_pin_a: assert property (pin_s2_q == $past(pin_s1_q))
		else $error("pin synchroniser skipped a stage");

	clr_none_a: assert property (blk_q[`IOCRB_B_ALANE] >= 3'(NCELL) |-> !aclr_blk)
		else $error("clear active with no lane chosen");

	clr_lane_a: assert property (blk_q[`IOCRB_B_ALANE] == 3'h0 |-> aclr_blk == io_caclr[0])
		else $error("shared clear not taken from its lane");

	oe_dflt_a: assert property (sel_q[0][`IOCRB_S_OE] >= 3'(NCELL) && !ctrl_q[0][`IOCRB_C_OEREG]
		|-> !pad_oe[0])
		else $error("unrouted output enable not low");

	oe_lane_a: assert property (sel_q[0][`IOCRB_S_OE] == 3'h1 && !ctrl_q[0][`IOCRB_C_OEREG]
		|-> pad_oe[0] == io_coe[1])
		else $error("output enable not from its lane");

	path_b_a: assert property (ctrl_q[0][`IOCRB_C_DLYB] == 3'h0 |-> io_datain_b[0] == pin_s2_q[0])
		else $error("undelayed path b not the pin");

	path_a_a: assert property (!ctrl_q[0][`IOCRB_C_INREG] && ctrl_q[0][`IOCRB_C_DLYA] == 3'h0
		|-> io_datain_a[0] == pin_s2_q[0])
		else $error("combinational path a not the pin");

	out_pass_a: assert property (!ctrl_q[0][`IOCRB_C_OUTREG] && ctrl_q[0][`IOCRB_C_DLYO] == 3'h0
		|-> pad_out[0] == io_dataout[0])
		else $error("unregistered output not passed through");

	wr_c: cover property (wr_en && wr_code_q == 4'h3);
	cfg_c: cover property (cfg_p_q);
endmodule : iocrb_top

//--- verif/iocrb_pin_model.sv
`timescale 1ns/10ps
module iocrb_pin_model (
	input wire logic [4:0] pad_out,
	input wire logic [4:0] pad_oe,
	input wire logic [4:0] ext_lvl,
	output logic [4:0] pad_in
);
	// Each pin shows the cell drive while enabled, else the outside driver.
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			pad_in[i] = pad_oe[i] ? pad_out[i] : ext_lvl[i];
		end
	end
endmodule : iocrb_pin_model

//--- verif/iocrb_tb_top.sv
`timescale 1ns/10ps
`include "iocrb_cfg.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module iocrb_tb_top;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [4:0] io_dataout = 5'h00;
	logic [4:0] io_coe = 5'h00;
	logic [4:0] io_cce_in = 5'h00;
	logic [4:0] io_cce_out = 5'h00;
	logic [4:0] io_cclk = 5'h00;
	logic [4:0] io_caclr = 5'h00;
	logic [4:0] io_csclr = 5'h00;
	logic [5:0] io_clk = 6'h00;
	logic [4:0] ext_lvl = 5'h1F;
	logic [4:0] pad_in;
	logic [4:0] pad_out;
	logic [4:0] pad_oe;
	logic [4:0] io_datain_a;
	logic [4:0] io_datain_b;
	logic [31:0] qe[$];
	logic [31:0] qm[$];
	logic [31:0] me;
	logic [31:0] mm;
	logic [31:0] r;
	logic dph = 1'b0;
	int n_mismatch = 0;
	int total_checks = 0;
	assign hready = hreadyout;
	iocrb_top #(.COLUMN_MODE(1'b0)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .io_dataout(io_dataout), .io_coe(io_coe),
		.io_cce_in(io_cce_in), .io_cce_out(io_cce_out), .io_cclk(io_cclk), .io_caclr(io_caclr),
		.io_csclr(io_csclr), .io_clk(io_clk), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.io_datain_a(io_datain_a), .io_datain_b(io_datain_b));
	iocrb_pin_model i_pin (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext_lvl), .pad_in(pad_in));
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
	endtask : ahb
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
		qe.push_back(e);
		qm.push_back(m);
		ahb(1'b0, a, 32'h00000000);
	endtask : rd
	// Read results are compared in the data phase against the oldest note.
	always @(posedge ref_clk) begin
		if (dph && hreadyout === 1'b1 && qe.size() > 0) begin
			me = qe.pop_front();
			mm = qm.pop_front();
			`CHK(hrdata & mm, me)
			`CHK(hresp, 1'b0)
		end
		dph <= hsel & htrans[1] & ~hwrite & hreadyout;
	end
	task automatic summarize;
		$display("mismatches %0d checks %0d", n_mismatch, total_checks);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize
	initial begin
		cyc(3000);
		n_mismatch++;
		summarize();
	end
	initial begin
		r = $urandom(14453);
		cyc(4);
		rst_b <= 1'b1;
		cyc(1);
		rd(`IOCRB_BLK_OFS, `IOCRB_BLK_RST, 32'hFFFFFFFF);
		rd(`IOCRB_CELL_OFS, `IOCRB_CTRL_RST, 32'hFFFFFFFF);
		rd(`IOCRB_CELL_OFS + 32'h0C, `IOCRB_SEL_RST, 32'hFFFFFFFF);
		rd(32'h00000100, 32'h00000000, 32'hFFFFFFFF);
		r = $urandom;
		ahb(1'b1, `IOCRB_CELL_OFS + 32'h08, r);
		rd(`IOCRB_CELL_OFS + 32'h08, r & `IOCRB_CTRL_MASK, 32'hFFFFFFFF);
		// Cell 0: registered out and oe, power-up high, in clock io_clk[0], out clock io_cclk[0].
		ahb(1'b1, `IOCRB_CELL_OFS, 32'h00000340);
		ahb(1'b1, `IOCRB_CELL_OFS + 32'h04, 32'h00005000);
		ahb(1'b1, `IOCRB_BLK_OFS, 32'h00000001);
		cyc(4);
		rd(`IOCRB_STAT_OFS, 32'h00000421, 32'h00000421);
		`CHK(pad_out[0], 1'b1)
		`CHK(pad_oe[0], 1'b1)
		io_cce_out <= 5'h01;
		io_cclk <= 5'h01;
		cyc(1);
		io_cclk <= 5'h00;
		cyc(2);
		rd(`IOCRB_STAT_OFS, 32'h00000001, 32'h00000421);
		`CHK(pad_out[0], 1'b0)
		io_cce_out <= 5'h00;
		io_dataout <= 5'h1F;
		io_coe <= 5'h1F;
		io_cclk <= 5'h01;
		cyc(1);
		io_cclk <= 5'h00;
		cyc(2);
		rd(`IOCRB_STAT_OFS, 32'h00000001, 32'h00000421);
		ext_lvl <= 5'h00;
		io_cce_in <= 5'h01;
		cyc(6);
		io_clk <= 6'h01;
		cyc(1);
		io_clk <= 6'h00;
		cyc(2);
		rd(`IOCRB_STAT_OFS, 32'h00000000, 32'h00000421);
		`CHK(io_datain_b[0], 1'b0)
		`CHK(io_datain_a[0], 1'b0)
		io_caclr <= 5'h01;
		cyc(2);
		io_caclr <= 5'h00;
		cyc(1);
		rd(`IOCRB_STAT_OFS, 32'h00000421, 32'h00000421);
		ahb(1'b1, `IOCRB_CELL_OFS, 32'h00000300);
		io_caclr <= 5'h01;
		cyc(2);
		io_caclr <= 5'h00;
		cyc(1);
		rd(`IOCRB_STAT_OFS, 32'h00000000, 32'h00000421);
		ahb(1'b1, `IOCRB_CELL_OFS, 32'h00000340);
		io_csclr <= 5'h01;
		io_cclk <= 5'h01;
		cyc(1);
		io_cclk <= 5'h00;
		io_csclr <= 5'h00;
		cyc(2);
		rd(`IOCRB_STAT_OFS, 32'h00000420, 32'h00000421);
		cyc(3);
		summarize();
	end
endmodule : iocrb_tb_top
